//--- hdl/psc_pkg.sv
// Purpose: constants and types for the power switchover control block
// Assumes: 8-bit special function register access, one clock
// Notes: offsets are special function register addresses
package psc_pkg;

    // register addresses
    localparam logic [7:0] PSC_ADDR_IRQ_ENABLE_PRIORITY_2 = 8'hA9;
    localparam logic [7:0] PSC_ADDR_WRITE_KEY_REGISTER = 8'hC1;
    localparam logic [7:0] PSC_ADDR_POWER_CONTROL = 8'hC5;
    localparam logic [7:0] PSC_ADDR_SUPPLY_EVENT_ENABLE = 8'hEC;
    localparam logic [7:0] PSC_ADDR_PERIPHERAL_CONFIG = 8'hF4;
    localparam logic [7:0] PSC_ADDR_SWITCHOVER_CONFIG = 8'hF5;
    localparam logic [7:0] PSC_ADDR_SUPPLY_EVENT_FLAGS = 8'hF8;
    localparam logic [7:0] PSC_ADDR_SCRATCH_PAD_3 = 8'hFD;
    localparam logic [7:0] PSC_ADDR_SCRATCH_PAD_4 = 8'hFE;
    localparam logic [7:0] PSC_ADDR_INTERRUPT_PIN_CONFIG = 8'hFF;

    // key value that opens one power control write
    localparam logic [7:0] PSC_WRITE_KEY = 8'hA7;

    // power control fields
    localparam int PSC_PWR_METER_OFF_BIT = 6;
    localparam int PSC_PWR_RESERVED_ZERO_BIT = 5;
    localparam int PSC_PWR_CORE_SHUTDOWN_BIT = 4;
    localparam logic [7:0] PSC_PWR_WRITABLE_MASK = 8'h57;
    localparam logic [7:0] PSC_PWR_FIXED_ONES = 8'h80;
    localparam logic [7:0] PSC_PWR_RESET = 8'h82;
    localparam logic [2:0] PSC_CLOCK_DIVIDE_RESET = 3'h2;

    // switchover configuration fields
    localparam int PSC_SW_DISABLE_BIT = 1;
    localparam logic [1:0] PSC_SEL_MAIN_ONLY = 2'h0;
    localparam logic [1:0] PSC_SEL_MAIN_OR_SUPERVISORY = 2'h1;
    localparam logic [7:0] PSC_SW_CONFIG_MASK = 8'h03;
    localparam logic [7:0] PSC_SW_CONFIG_RESET = 8'h00;

    // peripheral configuration status bit
    localparam int PSC_SUPPLY_SOURCE_STATUS_BIT = 6;

    // interrupt pin configuration, ext int1 field bits [2:1] select the pin
    localparam logic [1:0] PSC_INT1_BATTERY_PIN = 2'h1;
    localparam logic [7:0] PSC_INT_PIN_CONFIG_RESET = 8'h00;

    // supply event flag and enable bits
    localparam int PSC_EVT_SWITCHOVER_BIT = 1;
    localparam int PSC_EVT_RESTORED_BIT = 7;
    localparam logic [7:0] PSC_EVT_MASK = 8'h82;
    localparam logic [7:0] PSC_EVT_RESET = 8'h00;

    // irq enable and priority 2 bit that gates the supply interrupt
    localparam int PSC_SUPPLY_IRQ_ENABLE_BIT = 1;
    localparam logic [7:0] PSC_IRQ_EP2_RESET = 8'h00;

    localparam logic [7:0] PSC_SCRATCH_RESET = 8'h00;
    localparam logic [7:0] PSC_READ_ZERO = 8'h00;

    // input synchroniser bit positions
    localparam int PSC_SYNC_WIDTH = 3;
    localparam int PSC_SYNC_MAIN_LOW = 0;
    localparam int PSC_SYNC_SUPERVISORY_LOW = 1;
    localparam int PSC_SYNC_PIN = 2;
    localparam logic [2:0] PSC_SYNC_RESET = 3'h4;

    typedef enum logic [0:0] {
        PSC_ON_MAIN = 1'b0,
        PSC_ON_BATTERY = 1'b1
    } psc_rail_e;

endpackage : psc_pkg

//--- hdl/psc_sync.sv
// Purpose: two flip-flop synchroniser, one chain per bit
// Assumes: inputs are asynchronous to ref_clk_i
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module psc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;

    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
                stage1_reg[g] <= RESET_VALUE[g];
                sync_o[g] <= RESET_VALUE[g];
            end else begin
                stage1_reg[g] <= async_i[g];
                sync_o[g] <= stage1_reg[g];
            end
        end
    end

endmodule : psc_sync

//--- hdl/psc_power_switchover_control.sv
// Purpose: power control, battery switchover and supply event interrupt logic
// Assumes: registers reached by 8-bit special function register writes and reads
// Notes: scratch pads reset only on both_supplies_lost_i
`timescale 1ns/1ps
module psc_power_switchover_control (
    // clock and resets
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic both_supplies_lost_i,
    // special function register access
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    output logic [7:0] sfr_rdata_o,
    // comparator and pin inputs
    input wire logic main_low_i,
    input wire logic supervisory_low_i,
    input wire logic battery_control_pin_i,
    // power outputs
    output logic rail_on_battery_o,
    output logic metering_off_o,
    output logic sleep_mode_o,
    output logic [2:0] clock_divide_field_o,
    // interrupt to core
    output logic supply_irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisation

    logic [psc_pkg::PSC_SYNC_WIDTH-1:0] sync_w;
    logic main_low_s;
    logic supervisory_low_s;
    logic pin_s;
    logic pin_prev_reg;

    psc_sync #(
        .WIDTH(psc_pkg::PSC_SYNC_WIDTH),
        .RESET_VALUE(psc_pkg::PSC_SYNC_RESET)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .async_i({battery_control_pin_i, supervisory_low_i, main_low_i}),
        .sync_o(sync_w)
    );

    assign main_low_s = sync_w[psc_pkg::PSC_SYNC_MAIN_LOW];
    assign supervisory_low_s = sync_w[psc_pkg::PSC_SYNC_SUPERVISORY_LOW];
    assign pin_s = sync_w[psc_pkg::PSC_SYNC_PIN];

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_prev_reg <= 1'b1;
        end else begin
            pin_prev_reg <= pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register decode and key

    logic wr_power_control;
    logic wr_key;
    logic key_armed_reg;
    logic pwr_accept;

    assign wr_power_control = sfr_we_i && (sfr_addr_i == psc_pkg::PSC_ADDR_POWER_CONTROL);
    assign wr_key = sfr_we_i && (sfr_addr_i == psc_pkg::PSC_ADDR_WRITE_KEY_REGISTER);
    assign pwr_accept = wr_power_control && key_armed_reg;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            key_armed_reg <= 1'b0;
        end else if (sfr_we_i) begin
            key_armed_reg <= wr_key && (sfr_wdata_i == psc_pkg::PSC_WRITE_KEY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power control register

    logic [7:0] power_control_reg;
    logic [7:0] power_control_next;

    always_comb begin
        power_control_next = (sfr_wdata_i & psc_pkg::PSC_PWR_WRITABLE_MASK)
            | psc_pkg::PSC_PWR_FIXED_ONES;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_control_reg <= psc_pkg::PSC_PWR_RESET;
        end else if (pwr_accept) begin
            power_control_reg <= power_control_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0] switchover_config_reg;
    logic [7:0] interrupt_pin_config_reg;
    logic [7:0] supply_event_enable_reg;
    logic [7:0] irq_enable_priority_2_reg;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            switchover_config_reg <= psc_pkg::PSC_SW_CONFIG_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SWITCHOVER_CONFIG) begin
            switchover_config_reg <= sfr_wdata_i & psc_pkg::PSC_SW_CONFIG_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            interrupt_pin_config_reg <= psc_pkg::PSC_INT_PIN_CONFIG_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_INTERRUPT_PIN_CONFIG) begin
            interrupt_pin_config_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            supply_event_enable_reg <= psc_pkg::PSC_EVT_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SUPPLY_EVENT_ENABLE) begin
            supply_event_enable_reg <= sfr_wdata_i & psc_pkg::PSC_EVT_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_enable_priority_2_reg <= psc_pkg::PSC_IRQ_EP2_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_IRQ_ENABLE_PRIORITY_2) begin
            irq_enable_priority_2_reg <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scratch pads, retained across every reset but total supply loss

    logic [7:0] scratch_pad_3_reg;
    logic [7:0] scratch_pad_4_reg;

    always_ff @(posedge ref_clk_i or posedge both_supplies_lost_i) begin
        if (both_supplies_lost_i) begin
            scratch_pad_3_reg <= psc_pkg::PSC_SCRATCH_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SCRATCH_PAD_3) begin
            scratch_pad_3_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge both_supplies_lost_i) begin
        if (both_supplies_lost_i) begin
            scratch_pad_4_reg <= psc_pkg::PSC_SCRATCH_RESET;
        end else if (sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SCRATCH_PAD_4) begin
            scratch_pad_4_reg <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // switchover decision

    logic [1:0] switchover_select;
    logic switchover_enabled;
    logic pin_enabled;
    logic pin_fall;
    logic go_battery;
    logic go_main;
    psc_pkg::psc_rail_e rail_reg;
    psc_pkg::psc_rail_e rail_next;

    assign switchover_select = switchover_config_reg[1:0];
    assign switchover_enabled = !switchover_config_reg[psc_pkg::PSC_SW_DISABLE_BIT];
    assign pin_enabled = interrupt_pin_config_reg[2:1] == psc_pkg::PSC_INT1_BATTERY_PIN;
    assign pin_fall = pin_prev_reg && !pin_s;

    always_comb begin
        go_battery = switchover_enabled
            && (main_low_s
            || (switchover_select == psc_pkg::PSC_SEL_MAIN_OR_SUPERVISORY
                && supervisory_low_s)
            || (pin_enabled && pin_fall));
        go_main = !switchover_enabled
            || (!main_low_s
            && (switchover_select != psc_pkg::PSC_SEL_MAIN_OR_SUPERVISORY
                || !supervisory_low_s)
            && (!pin_enabled || pin_s));
    end

    always_comb begin
        rail_next = rail_reg;
        unique case (rail_reg)
            psc_pkg::PSC_ON_MAIN: begin
                if (go_battery) begin
                    rail_next = psc_pkg::PSC_ON_BATTERY;
                end
            end
            psc_pkg::PSC_ON_BATTERY: begin
                if (go_main) begin
                    rail_next = psc_pkg::PSC_ON_MAIN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rail_reg <= psc_pkg::PSC_ON_MAIN;
        end else begin
            rail_reg <= rail_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // supply event flags and interrupt

    logic [7:0] supply_event_flags_reg;
    logic [7:0] event_set;
    logic [7:0] flags_keep;
    logic wr_flags;

    assign wr_flags = sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SUPPLY_EVENT_FLAGS;

    always_comb begin
        event_set = psc_pkg::PSC_READ_ZERO;
        event_set[psc_pkg::PSC_EVT_SWITCHOVER_BIT] =
            rail_reg == psc_pkg::PSC_ON_MAIN && rail_next == psc_pkg::PSC_ON_BATTERY;
        event_set[psc_pkg::PSC_EVT_RESTORED_BIT] =
            rail_reg == psc_pkg::PSC_ON_BATTERY && rail_next == psc_pkg::PSC_ON_MAIN;
        flags_keep = wr_flags ? sfr_wdata_i : psc_pkg::PSC_EVT_MASK;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            supply_event_flags_reg <= psc_pkg::PSC_EVT_RESET;
        end else begin
            supply_event_flags_reg <= ((supply_event_flags_reg & flags_keep) | event_set)
                & psc_pkg::PSC_EVT_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            supply_irq_o <= 1'b0;
        end else begin
            supply_irq_o <= irq_enable_priority_2_reg[psc_pkg::PSC_SUPPLY_IRQ_ENABLE_BIT]
                && |(supply_event_flags_reg & supply_event_enable_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power outputs

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rail_on_battery_o <= 1'b0;
            metering_off_o <= 1'b0;
            sleep_mode_o <= 1'b0;
            clock_divide_field_o <= psc_pkg::PSC_CLOCK_DIVIDE_RESET;
        end else begin
            rail_on_battery_o <= rail_reg == psc_pkg::PSC_ON_BATTERY;
            metering_off_o <= power_control_reg[psc_pkg::PSC_PWR_METER_OFF_BIT]
                || rail_reg == psc_pkg::PSC_ON_BATTERY;
            sleep_mode_o <= power_control_reg[psc_pkg::PSC_PWR_CORE_SHUTDOWN_BIT]
                && rail_reg == psc_pkg::PSC_ON_BATTERY;
            clock_divide_field_o <= power_control_reg[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0] read_mux;

    always_comb begin
        read_mux = psc_pkg::PSC_READ_ZERO;
        unique case (sfr_addr_i)
            psc_pkg::PSC_ADDR_POWER_CONTROL: read_mux = power_control_reg;
            psc_pkg::PSC_ADDR_SWITCHOVER_CONFIG: read_mux = switchover_config_reg;
            psc_pkg::PSC_ADDR_INTERRUPT_PIN_CONFIG: read_mux = interrupt_pin_config_reg;
            psc_pkg::PSC_ADDR_SUPPLY_EVENT_ENABLE: read_mux = supply_event_enable_reg;
            psc_pkg::PSC_ADDR_SUPPLY_EVENT_FLAGS: read_mux = supply_event_flags_reg;
            psc_pkg::PSC_ADDR_IRQ_ENABLE_PRIORITY_2: read_mux = irq_enable_priority_2_reg;
            psc_pkg::PSC_ADDR_SCRATCH_PAD_3: read_mux = scratch_pad_3_reg;
            psc_pkg::PSC_ADDR_SCRATCH_PAD_4: read_mux = scratch_pad_4_reg;
            psc_pkg::PSC_ADDR_PERIPHERAL_CONFIG: begin
                read_mux[psc_pkg::PSC_SUPPLY_SOURCE_STATUS_BIT] =
                    rail_reg == psc_pkg::PSC_ON_MAIN;
            end
            default: read_mux = psc_pkg::PSC_READ_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sfr_rdata_o <= psc_pkg::PSC_READ_ZERO;
        end else begin
            sfr_rdata_o <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence key_then_pwr_write;
        (wr_key && sfr_wdata_i == psc_pkg::PSC_WRITE_KEY) ##1 wr_power_control;
    endsequence

    sequence unkeyed_pwr_write;
        !key_armed_reg && wr_power_control;
    endsequence

    AST_KEYED_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        key_then_pwr_write |=> power_control_reg == $past(power_control_next))
        else $error("keyed power control write not taken");

    AST_UNKEYED_IGNORED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        unkeyed_pwr_write |=> $stable(power_control_reg))
        else $error("power control changed without key");

    AST_RESERVED_ZERO: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !power_control_reg[psc_pkg::PSC_PWR_RESERVED_ZERO_BIT])
        else $error("power control bit 5 set");

    AST_SCRATCH_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (both_supplies_lost_i)
        !(sfr_we_i && sfr_addr_i == psc_pkg::PSC_ADDR_SCRATCH_PAD_3)
        |=> $stable(scratch_pad_3_reg))
        else $error("scratch pad changed without write");

    AST_BATTERY_MAIN_LOW: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rail_reg == psc_pkg::PSC_ON_MAIN && switchover_enabled && main_low_s)
        |=> rail_reg == psc_pkg::PSC_ON_BATTERY ##1 rail_on_battery_o)
        else $error("main supply low did not switch rail");

    AST_BATTERY_SUPERVISORY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rail_reg == psc_pkg::PSC_ON_MAIN && supervisory_low_s
        && switchover_config_reg[1:0] == psc_pkg::PSC_SEL_MAIN_OR_SUPERVISORY)
        |=> rail_reg == psc_pkg::PSC_ON_BATTERY)
        else $error("supervisory low did not switch rail");

    AST_DISABLED_STAYS_MAIN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !switchover_enabled[*2] |-> rail_reg == psc_pkg::PSC_ON_MAIN)
        else $error("rail on battery while switchover disabled");

    AST_RETURN_NEEDS_PIN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rail_reg == psc_pkg::PSC_ON_BATTERY && switchover_enabled && pin_enabled && !pin_s)
        |=> rail_reg == psc_pkg::PSC_ON_BATTERY)
        else $error("returned to main with pin low");

    AST_METER_ON_BATTERY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rail_reg == psc_pkg::PSC_ON_BATTERY |=> metering_off_o)
        else $error("metering live on battery");

    AST_SWITCHOVER_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(rail_reg) |-> supply_event_flags_reg[psc_pkg::PSC_EVT_SWITCHOVER_BIT])
        else $error("switchover flag not set");

    AST_FLAG_LATCHED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (supply_event_flags_reg[psc_pkg::PSC_EVT_RESTORED_BIT] && !wr_flags)
        |=> supply_event_flags_reg[psc_pkg::PSC_EVT_RESTORED_BIT])
        else $error("restored flag dropped without write");

    AST_IRQ_GATED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !irq_enable_priority_2_reg[psc_pkg::PSC_SUPPLY_IRQ_ENABLE_BIT] |=> !supply_irq_o)
        else $error("interrupt without global enable");

endmodule : psc_power_switchover_control

//--- tb/test_psc_power_switchover_control.sv
// Purpose: self-checking bench for the power switchover control block
// Assumes: inputs change on the falling edge, read data is registered
// Notes: assertions live in the design files
`timescale 1ns/1ps
module test_psc_power_switchover_control;
////////////////////////////////////////////////////////////////////////
logic clk, rst, lost, we, ml, sl, pin, bat, moff, slp, irq;
logic [7:0] addr, wdat, rdat;
logic [2:0] cd;
int failures = 0;
int checked = 0;
psc_power_switchover_control DUT (.ref_clk_i(clk), .reset_i(rst),
    .both_supplies_lost_i(lost), .sfr_addr_i(addr), .sfr_wdata_i(wdat),
    .sfr_we_i(we), .sfr_rdata_o(rdat), .main_low_i(ml), .supervisory_low_i(sl),
    .battery_control_pin_i(pin), .rail_on_battery_o(bat), .metering_off_o(moff),
    .sleep_mode_o(slp), .clock_divide_field_o(cd), .supply_irq_o(irq));
initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask : wrap_up
task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
        failures++;
        $display("[ERR] %s expected %h seen %h", n, e, s);
    end
endtask : chk8
task automatic chk1(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
        failures++;
        $display("[ERR] %s expected %b seen %b", n, e, s);
    end
endtask : chk1
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
endtask : wr
// key write then power control write on the next cycle
task automatic pw(input logic [7:0] d);
    @(negedge clk);
    addr = 8'hC1;
    wdat = 8'hA7;
    we = 1'b1;
    @(negedge clk);
    addr = 8'hC5;
    wdat = d;
    @(negedge clk);
    we = 1'b0;
    repeat (2) @(negedge clk);
endtask : pw
task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk8("read data", e, rdat);
endtask : rd
task automatic wait_rail(input logic e);
    for (int i = 0; i < 20 && bat !== e; i++) begin
        @(negedge clk);
    end
    chk1("rail", e, bat);
    if (bat !== e) begin
        wrap_up();
    end else begin
        @(negedge clk);
    end
endtask : wait_rail
task automatic stay(input logic e);
    repeat (10) @(negedge clk);
    chk1("rail held", e, bat);
endtask : stay
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    chk1("rail", 1'b0, bat);
    chk1("irq", 1'b0, irq);
    chk8("divide", 8'h02, {5'h00, cd});
    rd(8'hC5, 8'h82);
    rd(8'hF4, 8'h40);
    rd(8'hF5, 8'h00);
    rd(8'hF8, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'hC1, 8'h00);
    $display("test reset done");
endtask : t_reset
task automatic t_key;
    wr(8'hC5, 8'h57);
    rd(8'hC5, 8'h82);
    wr(8'hC1, 8'hA6);
    wr(8'hC5, 8'h57);
    rd(8'hC5, 8'h82);
    wr(8'hC1, 8'hA7);
    wr(8'hFE, 8'h00);
    wr(8'hC5, 8'h57);
    rd(8'hC5, 8'h82);
    pw(8'h5F);
    rd(8'hC5, 8'hD7);
    chk1("meter off", 1'b1, moff);
    for (int d = 0; d < 8; d++) begin
        pw(8'(d));
        chk8("divide", 8'(d), {5'h00, cd});
    end
    pw(8'h02);
    chk1("meter off", 1'b0, moff);
    $display("test key done");
endtask : t_key
task automatic t_scratch;
    wr(8'hFD, 8'hA5);
    wr(8'hFE, 8'h5A);
    rd(8'hFD, 8'hA5);
    rd(8'hFE, 8'h5A);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'hFD, 8'hA5);
    lost = 1'b1;
    @(negedge clk);
    lost = 1'b0;
    rd(8'hFD, 8'h00);
    rd(8'hFE, 8'h00);
    $display("test scratch done");
endtask : t_scratch
task automatic t_main;
    wr(8'hEC, 8'h82);
    wr(8'hA9, 8'h02);
    ml = 1'b1;
    wait_rail(1'b1);
    chk1("meter off", 1'b1, moff);
    chk8("divide", 8'h02, {5'h00, cd});
    chk1("irq", 1'b1, irq);
    rd(8'hF4, 8'h00);
    rd(8'hF8, 8'h02);
    pw(8'h12);
    chk1("sleep", 1'b1, slp);
    pw(8'h02);
    chk1("sleep", 1'b0, slp);
    ml = 1'b0;
    wait_rail(1'b0);
    rd(8'hF8, 8'h82);
    wr(8'hF8, 8'h80);
    rd(8'hF8, 8'h80);
    chk1("irq", 1'b1, irq);
    wr(8'hEC, 8'h02);
    rd(8'hF8, 8'h80);
    chk1("irq", 1'b0, irq);
    wr(8'hF8, 8'h00);
    rd(8'hF8, 8'h00);
    $display("test main done");
endtask : t_main
task automatic t_sup;
    wr(8'hA9, 8'h00);
    sl = 1'b1;
    stay(1'b0);
    wr(8'hF5, 8'h01);
    wait_rail(1'b1);
    stay(1'b1);
    chk1("irq", 1'b0, irq);
    wr(8'hA9, 8'h02);
    rd(8'hF8, 8'h02);
    chk1("irq", 1'b1, irq);
    sl = 1'b0;
    wait_rail(1'b0);
    wr(8'hF8, 8'h00);
    wr(8'hF5, 8'h00);
    $display("test supervisory done");
endtask : t_sup
task automatic t_pin;
    wr(8'hFF, 8'h02);
    pin = 1'b0;
    wait_rail(1'b1);
    ml = 1'b1;
    pin = 1'b1;
    stay(1'b1);
    ml = 1'b0;
    wait_rail(1'b0);
    pin = 1'b0;
    wait_rail(1'b1);
    stay(1'b1);
    pin = 1'b1;
    wait_rail(1'b0);
    wr(8'hF5, 8'h02);
    ml = 1'b1;
    stay(1'b0);
    rd(8'hF4, 8'h40);
    ml = 1'b0;
    $display("test pin done");
endtask : t_pin
////////////////////////////////////////////////////////////////////////
initial begin
    rst = 1'b1;
    lost = 1'b1;
    addr = 8'h00;
    wdat = 8'h00;
    we = 1'b0;
    ml = 1'b0;
    sl = 1'b0;
    pin = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    lost = 1'b0;
    t_reset();
    t_key();
    t_scratch();
    t_main();
    t_sup();
    t_pin();
    wrap_up();
end
endmodule : test_psc_power_switchover_control
